// ### rtl/fph_pkg.sv
// Package: constants, carriers and states of the frame policer hierarchy
package fph_pkg;
	// Table sizes
	localparam int NACL = 32;
	localparam int NSTORM = 8;
	localparam int NPORT = 4;
	localparam int NBUM = 4;
	localparam int NDLB = 8;
	// Bucket numbering: all single and dual buckets share one level array
	localparam int B_ACL = 0;
	localparam int B_STORM = 32;
	localparam int B_PORT = 40;
	localparam int B_BUM = 44;
	localparam int B_SVC = 56;
	localparam int NB = 88;
	localparam int BW = 7;
	localparam int LW = 24;
	localparam int AW = 10;
	localparam int BUM_CLASSES = 3;
	// Timing: leak ticks remove rate bytes per tick, rate times COARSE_MULT on coarse dual buckets
	localparam longint CLK_HZ = 40000000;
	localparam longint SLB_STEP_BPS = 25040;
	localparam longint DLB_STEP_BPS = 16000;
	localparam longint COARSE_STEP_BPS = 8000000;
	localparam int SLB_TICK = int'(CLK_HZ * 8 / SLB_STEP_BPS);
	localparam int DLB_TICK = int'(CLK_HZ * 8 / DLB_STEP_BPS);
	localparam int COARSE_MULT = int'(COARSE_STEP_BPS / DLB_STEP_BPS);
	localparam int THR_SHIFT = 11;
	// Register word addresses
	localparam logic [AW-1:0] OFF_CTL = 10'h000;
	localparam logic [AW-1:0] OFF_ACL_MODE = 10'h001;
	localparam logic [AW-1:0] OFF_STORM_MODE = 10'h002;
	localparam logic [AW-1:0] OFF_EVENTS = 10'h003;
	localparam logic [AW-1:0] OFF_PCTL = 10'h010;
	localparam logic [AW-1:0] OFF_DCFG = 10'h020;
	localparam logic [AW-1:0] OFF_BCFG = 10'h100;
	localparam logic [AW-1:0] OFF_LVL = 10'h200;
	// Event flag positions
	localparam int EV_ACL_DROP = 0;
	localparam int EV_PORT_DROP = 1;
	localparam int EV_STORM_DROP = 2;
	localparam int EV_BUM_DROP = 3;
	localparam int EV_DLB_DROP = 4;
	localparam int EV_CIR_EXC = 5;
	localparam int EV_PIR_EXC = 6;
	localparam int EV_OPEN = 7;
	localparam int NEV = 8;
	// Pipeline points: each value bypasses one more stage
	localparam logic [1:0] PP_NONE = 2'h0;
	localparam logic [1:0] PP_SVC = 2'h2;
	localparam logic [1:0] PP_BDL = 2'h3;

	typedef struct packed {
		logic [6:0] gap;
		logic [6:0] hyst;
		logic [6:0] thres;
		logic [10:0] rate;
	} fph_bcfg_t;

	typedef struct packed {
		logic [1:0] excess_precedence_increment;
		logic coupling;
		logic [1:0] green_precedence_limit;
		logic [1:0] rate_granularity_select;
	} fph_dcfg_t;

	typedef struct packed {
		logic flow_ctl;
		logic [2:0] port_bundle_index;
		logic [6:0] port_size_correction;
	} fph_pctl_t;

	typedef struct packed {
		logic [2:0] queue_policer_index;
		logic port_default_bundle_enable;
		logic queue_default_policer_enable;
	} fph_ctl_t;

	typedef struct packed {
		logic [1:0] port;
		logic [13:0] len;
		logic [1:0] drop_precedence;
		logic acl_en;
		logic [4:0] acl_idx;
		logic inner_policing_select;
		logic storm_en;
		logic [2:0] storm_idx;
		logic bum_en;
		logic [1:0] bum_idx;
		logic [1:0] bum_class;
		logic [7:0] service_index;
		logic [3:0] service_dual_bucket_index;
		logic [3:0] service_bundle_index;
		logic [1:0] policing_pipeline_point;
	} fph_req_t;

	typedef struct packed {
		logic drop;
		logic yellow;
		logic [1:0] drop_precedence;
	} fph_res_t;

	typedef struct packed {
		logic [2:0] policer;
		logic drop;
		logic yellow;
	} fph_stat_t;

	typedef enum logic [3:0] {
		S_IDLE = 4'b0000,
		S_OACL = 4'b0001,
		S_PORT = 4'b0010,
		S_STORM = 4'b0011,
		S_BUM = 4'b0100,
		S_SVC = 4'b0101,
		S_IACL = 4'b0110,
		S_BDL = 4'b0111,
		S_DONE = 4'b1000
	} fph_state_t;

	// Reset values
	localparam fph_bcfg_t BCFG_RST = '0;
	localparam fph_dcfg_t DCFG_RST = '0;
	localparam fph_pctl_t PCTL_RST = '0;
	localparam fph_ctl_t CTL_RST = '0;
endpackage

// ### rtl/fph_policer.sv
// Module: frame policer hierarchy with single and dual leaky buckets
// Function
// - At most one lookup policer per frame
// - Inner select places lookup after service policing
// - Lookup/port/BROADCAST_UNICAST_MULTICAST/storm single, service/bundle dual buckets
// - BROADCAST_UNICAST_MULTICAST policer has broadcast, unicast, multicast buckets
// - Lookup/port/storm single bucket rates step 25,040 bit/s
// - Dual rates fine or coarse per granularity, BROADCAST_UNICAST_MULTICAST rates always fine
// - Queue policer when both service indexes zero
// - Bundle by service index, port default for non-service frames
// - Pipeline point bypasses BROADCAST_UNICAST_MULTICAST/service/bundle stages
// - Service statistics follow service colour decision
// - Signed size adjustment -64..63 per policer
// - Port policers add per-port size correction
// - Flow-control port policer uses hysteresis threshold
// - Thirty-two lookup policers, own mode/rate/burst
// - Eight storm policers, own mode/rate/burst
// - Dual policer has 2-bit granularity field
// - Colour level limits green; 3 is colour-blind
// - Policer events kept in sticky readable flags
// - Green frames marked excess raise precedence by increment
// - Burst thresholds in 2 kilobyte steps
//
// The register offsets and strobed register access are this design's own decisions.
module fph_policer #(
	parameter int SLB_TICK_CYC = fph_pkg::SLB_TICK,
	parameter int DLB_TICK_CYC = fph_pkg::DLB_TICK
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [fph_pkg::AW-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic req_valid,
	output logic req_ready,
	input wire fph_pkg::fph_req_t req,
	output logic res_valid,
	output fph_pkg::fph_res_t res,
	output logic stat_valid,
	output fph_pkg::fph_stat_t stat,
	output logic [fph_pkg::NPORT-1:0] port_pause
);
	localparam int BW = fph_pkg::BW;
	localparam int LW = fph_pkg::LW;
	localparam int TW = $clog2(SLB_TICK_CYC > DLB_TICK_CYC ? SLB_TICK_CYC : DLB_TICK_CYC) + 1;

	// Address range test used by every table decode
	function automatic logic in_rng(input logic [fph_pkg::AW-1:0] a, input logic [fph_pkg::AW-1:0] base,
			input int n);
		in_rng = (a >= base) && (int'(a) < int'(base) + n);
	endfunction

	// Threshold in bytes from a 2 kilobyte step count
	function automatic logic [LW-1:0] thr_of(input fph_pkg::fph_bcfg_t c);
		thr_of = LW'(c.thres) << fph_pkg::THR_SHIFT;
	endfunction

	fph_pkg::fph_bcfg_t bcfg_r [fph_pkg::NB];
	fph_pkg::fph_dcfg_t dcfg_r [2*fph_pkg::NDLB];
	fph_pkg::fph_pctl_t pctl_r [fph_pkg::NPORT];
	fph_pkg::fph_ctl_t ctl_r;
	logic [fph_pkg::NACL-1:0] acl_mode_r;
	logic [fph_pkg::NSTORM-1:0] storm_mode_r;
	logic [fph_pkg::NEV-1:0] ev_r;
	logic [fph_pkg::NEV-1:0] ev_set;
	logic [LW-1:0] lvl_r [fph_pkg::NB];
	logic [LW-1:0] lvl_nxt [fph_pkg::NB];
	logic [31:0] rd_word;
	logic [31:0] reg_rdata_r;
	logic [TW-1:0] slb_cnt_r;
	logic [TW-1:0] dlb_cnt_r;
	logic slb_tick_r;
	logic dlb_tick_r;
	fph_pkg::fph_state_t st_r;
	fph_pkg::fph_state_t st_nxt;
	fph_pkg::fph_req_t req_r;
	logic [1:0] dp_r;
	logic yel_r;
	logic drop_r;
	logic ready_r;
	logic res_valid_r;
	fph_pkg::fph_res_t res_r;
	logic stat_valid_r;
	fph_pkg::fph_stat_t stat_r;
	logic [fph_pkg::NPORT-1:0] pause_r;

	// Register write decode
	wire wr_ctl = reg_wr && (reg_addr == fph_pkg::OFF_CTL);
	wire wr_acl = reg_wr && (reg_addr == fph_pkg::OFF_ACL_MODE);
	wire wr_storm = reg_wr && (reg_addr == fph_pkg::OFF_STORM_MODE);
	wire wr_ev = reg_wr && (reg_addr == fph_pkg::OFF_EVENTS);
	wire wr_pctl = reg_wr && in_rng(reg_addr, fph_pkg::OFF_PCTL, fph_pkg::NPORT);
	wire wr_dcfg = reg_wr && in_rng(reg_addr, fph_pkg::OFF_DCFG, 2*fph_pkg::NDLB);
	wire wr_bcfg = reg_wr && in_rng(reg_addr, fph_pkg::OFF_BCFG, fph_pkg::NB);
	wire [fph_pkg::AW-1:0] pctl_a = reg_addr - fph_pkg::OFF_PCTL;
	wire [fph_pkg::AW-1:0] dcfg_a = reg_addr - fph_pkg::OFF_DCFG;
	wire [fph_pkg::AW-1:0] bcfg_a = reg_addr - fph_pkg::OFF_BCFG;
	wire [fph_pkg::AW-1:0] lvl_a = reg_addr - fph_pkg::OFF_LVL;

	// Configuration storage; per-entry tables give each policer its own settings
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_r <= fph_pkg::CTL_RST;
			acl_mode_r <= '0;
			storm_mode_r <= '0;
			for (int i = 0; i < fph_pkg::NB; i++) bcfg_r[i] <= fph_pkg::BCFG_RST;
			for (int i = 0; i < 2*fph_pkg::NDLB; i++) dcfg_r[i] <= fph_pkg::DCFG_RST;
			for (int i = 0; i < fph_pkg::NPORT; i++) pctl_r[i] <= fph_pkg::PCTL_RST;
		end else begin
			if (wr_ctl) ctl_r <= reg_wdata[4:0];
			if (wr_acl) acl_mode_r <= reg_wdata;
			if (wr_storm) storm_mode_r <= reg_wdata[fph_pkg::NSTORM-1:0];
			if (wr_pctl) pctl_r[pctl_a[1:0]] <= reg_wdata[10:0];
			if (wr_dcfg) dcfg_r[dcfg_a[3:0]] <= reg_wdata[6:0];
			if (wr_bcfg) bcfg_r[bcfg_a[BW-1:0]] <= reg_wdata;
		end
	end

	// Sticky flags: a set in the clearing cycle survives
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) ev_r <= '0;
		else ev_r <= (ev_r & ~(wr_ev ? reg_wdata[fph_pkg::NEV-1:0] : '0)) | ev_set;
	end

	// Read selection; unmapped words read zero
	always_comb begin
		rd_word = '0;
		if (reg_addr == fph_pkg::OFF_CTL) rd_word = 32'(ctl_r);
		else if (reg_addr == fph_pkg::OFF_ACL_MODE) rd_word = acl_mode_r;
		else if (reg_addr == fph_pkg::OFF_STORM_MODE) rd_word = 32'(storm_mode_r);
		else if (reg_addr == fph_pkg::OFF_EVENTS) rd_word = 32'(ev_r);
		else if (in_rng(reg_addr, fph_pkg::OFF_PCTL, fph_pkg::NPORT)) rd_word = 32'(pctl_r[pctl_a[1:0]]);
		else if (in_rng(reg_addr, fph_pkg::OFF_DCFG, 2*fph_pkg::NDLB)) rd_word = 32'(dcfg_r[dcfg_a[3:0]]);
		else if (in_rng(reg_addr, fph_pkg::OFF_BCFG, fph_pkg::NB)) rd_word = bcfg_r[bcfg_a[BW-1:0]];
		else if (in_rng(reg_addr, fph_pkg::OFF_LVL, fph_pkg::NB)) rd_word = 32'(lvl_r[lvl_a[BW-1:0]]);
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) reg_rdata_r <= '0;
		else reg_rdata_r <= reg_rd ? rd_word : '0;
	end

	// Leak tick generators, one byte per rate unit per tick, COARSE_MULT bytes on coarse dual buckets
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slb_cnt_r <= '0;
			dlb_cnt_r <= '0;
			slb_tick_r <= 1'b0;
			dlb_tick_r <= 1'b0;
		end else begin
			slb_tick_r <= (slb_cnt_r == TW'(SLB_TICK_CYC - 1));
			dlb_tick_r <= (dlb_cnt_r == TW'(DLB_TICK_CYC - 1));
			slb_cnt_r <= (slb_cnt_r == TW'(SLB_TICK_CYC - 1)) ? '0 : slb_cnt_r + 1'b1;
			dlb_cnt_r <= (dlb_cnt_r == TW'(DLB_TICK_CYC - 1)) ? '0 : dlb_cnt_r + 1'b1;
		end
	end

	// Service and bundle policer selection
	wire svc_is = req_r.service_index != '0;
	wire svc_by_idx = req_r.service_dual_bucket_index != '0;
	wire svc_by_q = !svc_is && !svc_by_idx && ctl_r.queue_default_policer_enable;
	wire svc_ok = svc_by_idx || svc_by_q;
	wire [2:0] svc_d = svc_by_idx ? req_r.service_dual_bucket_index[2:0] : ctl_r.queue_policer_index;
	wire bdl_by_svc = svc_is && (req_r.service_bundle_index != '0);
	wire bdl_by_port = !svc_is && ctl_r.port_default_bundle_enable;
	wire [2:0] bdl_d = bdl_by_svc ? req_r.service_bundle_index[2:0] : pctl_r[req_r.port].port_bundle_index;
	wire [1:0] pp = req_r.policing_pipeline_point;

	// Stage selection: which bucket the current stage looks at
	logic cur_act;
	logic cur_dual;
	logic [3:0] cur_d;
	logic [BW-1:0] cur_b;
	always_comb begin
		cur_act = 1'b0;
		cur_dual = 1'b0;
		cur_d = '0;
		cur_b = '0;
		case (st_r)
			fph_pkg::S_OACL, fph_pkg::S_IACL: begin
				// At most one lookup stage fires, never both
				cur_act = req_r.acl_en && acl_mode_r[req_r.acl_idx]
					&& (req_r.inner_policing_select == (st_r == fph_pkg::S_IACL));
				cur_b = BW'(fph_pkg::B_ACL + int'(req_r.acl_idx));
			end
			fph_pkg::S_PORT: begin
				cur_act = 1'b1;
				cur_b = BW'(fph_pkg::B_PORT + int'(req_r.port));
			end
			fph_pkg::S_STORM: begin
				cur_act = req_r.storm_en && storm_mode_r[req_r.storm_idx];
				cur_b = BW'(fph_pkg::B_STORM + int'(req_r.storm_idx));
			end
			fph_pkg::S_BUM: begin
				// Class 3 has no bucket in the set of three
				cur_act = req_r.bum_en && (req_r.bum_class != 2'h3) && (pp == fph_pkg::PP_NONE);
				cur_b = BW'(fph_pkg::B_BUM + fph_pkg::BUM_CLASSES * int'(req_r.bum_idx) + int'(req_r.bum_class));
			end
			fph_pkg::S_SVC: begin
				cur_dual = 1'b1;
				cur_act = svc_ok && (pp < fph_pkg::PP_SVC);
				cur_d = {1'b0, svc_d};
				cur_b = BW'(fph_pkg::B_SVC + 2 * int'(svc_d));
			end
			fph_pkg::S_BDL: begin
				cur_dual = 1'b1;
				cur_act = (bdl_by_svc || bdl_by_port) && (pp < fph_pkg::PP_BDL);
				cur_d = {1'b1, bdl_d};
				cur_b = BW'(fph_pkg::B_SVC + 2 * (fph_pkg::NDLB + int'(bdl_d)));
			end
			default: begin
				cur_act = 1'b0;
			end
		endcase
	end

	// Bucket decision for the current stage
	wire [BW-1:0] cur_b1 = cur_b + 1'b1;
	wire ex0 = lvl_r[cur_b] > thr_of(bcfg_r[cur_b]);
	wire ex1 = lvl_r[cur_b1] > thr_of(bcfg_r[cur_b1]);
	fph_pkg::fph_dcfg_t dc;
	assign dc = dcfg_r[cur_d];
	wire green_in = dp_r <= dc.green_precedence_limit;
	wire take0 = green_in && !ex0;
	wire live = cur_act && !drop_r;
	wire flow = (st_r == fph_pkg::S_PORT) && pctl_r[req_r.port].flow_ctl;
	wire stage_drop = live && (cur_dual ? (!take0 && ex1) : (ex0 && !flow));
	wire stage_yel = live && cur_dual && !take0 && !ex1;
	wire add_en = live && !stage_drop;
	wire [BW-1:0] add_b = (cur_dual && !take0) ? cur_b1 : cur_b;
	wire [2:0] dp_sum = {1'b0, dp_r} + {1'b0, dc.excess_precedence_increment};
	wire [1:0] dp_inc = dp_sum[2] ? 2'h3 : dp_sum[1:0];

	// Adjusted length: signed gap per bucket, plus correction on port stage
	wire signed [15:0] gap_s = 16'(signed'(bcfg_r[add_b].gap));
	wire signed [15:0] corr_s = (st_r == fph_pkg::S_PORT)
		? 16'(signed'(pctl_r[req_r.port].port_size_correction)) : 16'sh0;
	wire signed [15:0] len_s = signed'({2'b00, req_r.len}) + gap_s + corr_s;
	wire [LW-1:0] add_len = len_s[15] ? '0 : LW'(len_s[14:0]);

	// Events from the stage in progress
	always_comb begin
		ev_set = '0;
		ev_set[fph_pkg::EV_ACL_DROP] = stage_drop && ((st_r == fph_pkg::S_OACL) || (st_r == fph_pkg::S_IACL));
		ev_set[fph_pkg::EV_PORT_DROP] = stage_drop && (st_r == fph_pkg::S_PORT);
		ev_set[fph_pkg::EV_STORM_DROP] = stage_drop && (st_r == fph_pkg::S_STORM);
		ev_set[fph_pkg::EV_BUM_DROP] = stage_drop && (st_r == fph_pkg::S_BUM);
		ev_set[fph_pkg::EV_DLB_DROP] = stage_drop && cur_dual;
		ev_set[fph_pkg::EV_CIR_EXC] = live && cur_dual && green_in && ex0;
		ev_set[fph_pkg::EV_PIR_EXC] = live && cur_dual && ex1 && !take0;
		ev_set[fph_pkg::EV_OPEN] = live && cur_dual && take0;
	end

	// Leaky buckets: drain on tick, fill by accepted frame length
	for (genvar gi = 0; gi < fph_pkg::NB; gi++) begin : g_bkt
		logic [LW-1:0] leak;
		logic [LW-1:0] drained;
		if (gi < fph_pkg::B_BUM) begin : g_slb
			assign leak = slb_tick_r ? LW'(bcfg_r[gi].rate) : '0;
		end else if (gi < fph_pkg::B_SVC) begin : g_bum
			// No per-set granularity field here, so these sets always use the fine step
			assign leak = dlb_tick_r ? LW'(bcfg_r[gi].rate) : '0;
		end else begin : g_dlb
			// Nonzero granularity uses the coarse step
			wire coarse = dcfg_r[(gi - fph_pkg::B_SVC) / 2].rate_granularity_select != 2'h0;
			assign leak = !dlb_tick_r ? '0
				: coarse ? LW'(int'(bcfg_r[gi].rate) * fph_pkg::COARSE_MULT) : LW'(bcfg_r[gi].rate);
		end
		assign drained = (lvl_r[gi] > leak) ? lvl_r[gi] - leak : '0;
		assign lvl_nxt[gi] = drained + ((add_en && (add_b == BW'(gi))) ? add_len : '0);
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) lvl_r[gi] <= '0;
			else lvl_r[gi] <= lvl_nxt[gi];
		end
	end

	// Flow control pause with hysteresis on each port bucket
	for (genvar gp = 0; gp < fph_pkg::NPORT; gp++) begin : g_pause
		localparam int PB = fph_pkg::B_PORT + gp;
		wire hi = lvl_r[PB] > thr_of(bcfg_r[PB]);
		wire lo = lvl_r[PB] <= (LW'(bcfg_r[PB].hyst) << fph_pkg::THR_SHIFT);
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) pause_r[gp] <= 1'b0;
			else if (!pctl_r[gp].flow_ctl || lo) pause_r[gp] <= 1'b0;
			else if (hi) pause_r[gp] <= 1'b1;
		end
	end

	// Fixed stage order for every frame
	always_comb begin
		case (st_r)
			fph_pkg::S_IDLE: st_nxt = (req_valid && ready_r) ? fph_pkg::S_OACL : fph_pkg::S_IDLE;
			fph_pkg::S_OACL: st_nxt = fph_pkg::S_PORT;
			fph_pkg::S_PORT: st_nxt = fph_pkg::S_STORM;
			fph_pkg::S_STORM: st_nxt = fph_pkg::S_BUM;
			fph_pkg::S_BUM: st_nxt = fph_pkg::S_SVC;
			fph_pkg::S_SVC: st_nxt = fph_pkg::S_IACL;
			fph_pkg::S_IACL: st_nxt = fph_pkg::S_BDL;
			fph_pkg::S_BDL: st_nxt = fph_pkg::S_DONE;
			default: st_nxt = fph_pkg::S_IDLE;
		endcase
	end

	// Frame state: verdict accumulates across stages
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= fph_pkg::S_IDLE;
			req_r <= '0;
			dp_r <= '0;
			yel_r <= 1'b0;
			drop_r <= 1'b0;
			ready_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			ready_r <= (st_nxt == fph_pkg::S_IDLE) && !(st_r == fph_pkg::S_IDLE && req_valid && ready_r);
			if (st_r == fph_pkg::S_IDLE && req_valid && ready_r) begin
				req_r <= req;
				dp_r <= req.drop_precedence;
				yel_r <= 1'b0;
				drop_r <= 1'b0;
			end else begin
				if (stage_drop) drop_r <= 1'b1;
				if (stage_yel) yel_r <= 1'b1;
				if (stage_yel && green_in) dp_r <= dp_inc;
			end
		end
	end

	// Result and service statistics outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			res_valid_r <= 1'b0;
			res_r <= '0;
			stat_valid_r <= 1'b0;
			stat_r <= '0;
		end else begin
			res_valid_r <= (st_r == fph_pkg::S_DONE);
			res_r <= {drop_r, yel_r, dp_r};
			// Reported now, even if a later stage discards the frame
			stat_valid_r <= live && (st_r == fph_pkg::S_SVC);
			stat_r <= {svc_d, stage_drop, stage_yel};
		end
	end

	assign reg_rdata = reg_rdata_r;
	assign req_ready = ready_r;
	assign res_valid = res_valid_r;
	assign res = res_r;
	assign stat_valid = stat_valid_r;
	assign stat = stat_r;
	assign port_pause = pause_r;
endmodule

// ### sim/fph_policer_props.sv
// Checker: timing and verdict relations at the frame policer ports
module fph_policer_props (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire fph_pkg::fph_req_t req,
	input wire logic res_valid,
	input wire fph_pkg::fph_res_t res,
	input wire logic stat_valid,
	input wire fph_pkg::fph_stat_t stat
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Frame taken by the block
	wire logic take;
	assign take = req_valid && req_ready;

	// Read data only in the slot after a read strobe
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data not zero outside read slot");
	// Verdict timing fixed by the stage walk, so a skipped stage shows up here
	verdict_lat_a: assert property (take |-> ##9 res_valid)
		else $error("verdict not nine cycles after take");
	ready_gap_a: assert property (take |=> !req_ready [*8] ##1 req_ready)
		else $error("ready not held off for one frame");
	verdict_ready_a: assert property (res_valid |-> req_ready && !$past(req_ready))
		else $error("verdict and ready out of step");
	// Service count comes before the later stages, even for frames dropped later
	stat_slot_a: assert property (stat_valid |-> $past(take, 6) ##3 res_valid)
		else $error("service decision out of its slot");
	stat_drop_a: assert property (stat_valid && stat.drop |-> ##3 (res_valid && res.drop))
		else $error("service drop not carried to verdict");
	pp_skip_a: assert property (take && req.policing_pipeline_point >= fph_pkg::PP_SVC |-> ##6 !stat_valid)
		else $error("service policer acted despite pipeline point");
	dp_rise_a: assert property (res_valid && !res.drop |-> res.drop_precedence >= $past(req.drop_precedence, 9))
		else $error("drop precedence lowered");
endmodule

bind fph_policer fph_policer_props chk_u (.clk(clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.req_valid(req_valid), .req_ready(req_ready), .req(req), .res_valid(res_valid), .res(res),
	.stat_valid(stat_valid), .stat(stat));

// ### sim/fph_frame_src.sv
// Frame source model standing in for the classification pipeline
module fph_frame_src (
	input wire logic clk,
	input wire logic req_ready,
	output logic req_valid,
	output fph_pkg::fph_req_t req,
	output logic hung
);
	timeunit 1ns;
	timeprecision 100ps;
	// Nothing offered at start
	initial begin
		req_valid = 1'b0;
		req = '1;
		hung = 1'b0;
	end
	// Offer after idle cycles, hold until ready is sampled high, then release
	task automatic send(input fph_pkg::fph_req_t r, input int idle);
		int n;
		n = 0;
		repeat (idle) @(posedge clk);
		@(posedge clk);
		req_valid <= 1'b1;
		req <= r;
		do begin
			@(posedge clk);
			n++;
		end while (req_ready !== 1'b1 && n < 40);
		req_valid <= 1'b0;
		req <= ~r; // Stale fields must not look like the last frame
		hung <= (n >= 40);
	endtask
endmodule

// ### sim/fph_policer_tb.sv
// Testbench: register and frame scenarios for the frame policer hierarchy
module fph_policer_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int SLB_T = 16;
	logic clk;
	logic rst_n;
	logic reg_wr;
	logic reg_rd;
	logic [fph_pkg::AW-1:0] reg_addr;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;
	logic [31:0] rd;
	logic req_valid;
	logic req_ready;
	logic res_valid;
	logic stat_valid;
	logic hung;
	logic [fph_pkg::NPORT-1:0] port_pause;
	fph_pkg::fph_req_t req;
	fph_pkg::fph_req_t f;
	fph_pkg::fph_res_t res;
	fph_pkg::fph_stat_t stat;
	int err_total;
	int checks_done;

	// Short leak ticks keep drain waits small
	fph_policer #(.SLB_TICK_CYC(SLB_T), .DLB_TICK_CYC(32)) dut_u (.clk(clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.req_valid(req_valid), .req_ready(req_ready), .req(req), .res_valid(res_valid), .res(res),
		.stat_valid(stat_valid), .stat(stat), .port_pause(port_pause));
	fph_frame_src src_u (.clk(clk), .req_ready(req_ready), .req_valid(req_valid), .req(req), .hung(hung));

	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", w, exp, seen);
		end
	endtask

	// Register bus: one-cycle strobes, read data in the following cycle
	task automatic wr(input logic [fph_pkg::AW-1:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rdreg(input logic [fph_pkg::AW-1:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	task automatic rchk(input string w, input logic [fph_pkg::AW-1:0] a, input logic [31:0] e);
		rdreg(a, rd);
		check(w, rd, e);
	endtask

	function automatic fph_pkg::fph_req_t mk(input logic [1:0] p, input logic [13:0] len, input logic [1:0] dp,
			input logic [3:0] sdb, input logic [3:0] sbi);
		fph_pkg::fph_req_t r;
		r = '0;
		r.port = p;
		r.len = len;
		r.drop_precedence = dp;
		r.bum_class = 2'h3;
		r.service_index = {7'h00, |{sdb, sbi}};
		r.service_dual_bucket_index = sdb;
		r.service_bundle_index = sbi;
		return r;
	endfunction

	// One frame; on a drop only the drop bits are compared, the rest is left open
	task automatic frame(input fph_pkg::fph_req_t r, input fph_pkg::fph_res_t er, input logic so,
			input fph_pkg::fph_stat_t es, input int idle);
		int n;
		logic got;
		fph_pkg::fph_stat_t st;
		n = 0;
		got = 1'b0;
		st = '0;
		src_u.send(r, idle);
		do begin
			@(posedge clk);
			#1;
			n++;
			if (stat_valid === 1'b1) begin
				got = 1'b1;
				st = stat;
			end
		end while (res_valid !== 1'b1 && n < 16);
		if (n >= 16 || hung === 1'b1) begin
			err_total++;
			results();
		end
		check("verdict", 32'(res & (er.drop ? 4'h8 : 4'hf)), 32'(er & (er.drop ? 4'h8 : 4'hf)));
		check("service seen", 32'(got), 32'(so));
		check("service result", 32'(st & (es.drop ? 5'h02 : 5'h1f)),
			32'(so ? es & (es.drop ? 5'h02 : 5'h1f) : 5'h00));
	endtask

	task automatic t_regs();
		rchk("ctl reset", fph_pkg::OFF_CTL, 32'h0);
		wr(fph_pkg::OFF_CTL, 32'hffffffff);
		rchk("ctl rw", fph_pkg::OFF_CTL, 32'h1f);
		wr(fph_pkg::OFF_CTL, 32'h0);
		wr(fph_pkg::OFF_DCFG + 10'h007, 32'hffffffff);
		rchk("dual cfg rw", fph_pkg::OFF_DCFG + 10'h007, 32'h7f);
		wr(fph_pkg::OFF_LVL, 32'hffff);
		rchk("level read only", fph_pkg::OFF_LVL, 32'h0);
		rchk("unmapped", 10'h3ff, 32'h0);
		$display("test regs done");
	endtask

	// Port 0: +4 correction, -2 adjust, 2048-byte threshold
	task automatic t_port();
		wr(fph_pkg::OFF_PCTL, 32'h4);
		wr(fph_pkg::OFF_BCFG + 10'h028, {7'h7e, 7'h00, 7'h01, 11'h000});
		wr(fph_pkg::OFF_STORM_MODE, 32'h1);
		frame(mk(2'h0, 14'h0064, 2'h0, 4'h0, 4'h0), '0, 1'b0, '0, 0);
		rchk("port level", fph_pkg::OFF_LVL + 10'h028, 32'h66);
		f = mk(2'h0, 14'h07d0, 2'h0, 4'h0, 4'h0);
		f.storm_en = 1'b1;
		frame(f, '0, 1'b0, '0, 0);
		rchk("port level full", fph_pkg::OFF_LVL + 10'h028, 32'h838);
		frame(f, '{1'b1, 1'b0, 2'h0}, 1'b0, '0, 3);
		rchk("storm level kept", fph_pkg::OFF_LVL + 10'h020, 32'h7d0);
		rchk("port drop flag", fph_pkg::OFF_EVENTS, 32'h2);
		wr(fph_pkg::OFF_EVENTS, 32'h2);
		rchk("flag cleared", fph_pkg::OFF_EVENTS, 32'h0);
		// Flow control: full bucket pauses instead of dropping, hysteresis releases it
		wr(fph_pkg::OFF_PCTL, 32'h404);
		frame(mk(2'h0, 14'h0064, 2'h0, 4'h0, 4'h0), '0, 1'b0, '0, 0);
		check("pause on", 32'(port_pause), 32'h1);
		wr(fph_pkg::OFF_BCFG + 10'h028, {7'h7e, 7'h02, 7'h01, 11'h000});
		rchk("flow level", fph_pkg::OFF_LVL + 10'h028, 32'h89e);
		check("pause off", 32'(port_pause), 32'h0);
		$display("test port done");
	endtask

	// Lookup 31 with a one-step rate; service 3 colour-blind and roomy
	task automatic t_lookup();
		for (int i = 1; i < 4; i++) begin
			wr(fph_pkg::OFF_BCFG + 10'(40 + i), 32'h0003f800);
		end
		wr(fph_pkg::OFF_DCFG + 10'h003, 32'h4c);
		wr(fph_pkg::OFF_BCFG + 10'h03e, 32'h0003f800);
		wr(fph_pkg::OFF_BCFG + 10'h03f, 32'h0003f800);
		wr(fph_pkg::OFF_ACL_MODE, 32'h80000000);
		wr(fph_pkg::OFF_BCFG + 10'h01f, 32'h1);
		f = mk(2'h1, 14'h0040, 2'h0, 4'h0, 4'h0);
		f.acl_en = 1'b1;
		f.acl_idx = 5'h1f;
		frame(f, '0, 1'b0, '0, 0);
		frame(f, '{1'b1, 1'b0, 2'h0}, 1'b0, '0, 0);
		f.inner_policing_select = 1'b1;
		f.service_index = 8'h01;
		f.service_dual_bucket_index = 4'hb;
		frame(f, '{1'b1, 1'b0, 2'h0}, 1'b1, '{3'h3, 1'b0, 1'b0}, 0);
		rchk("port level", fph_pkg::OFF_LVL + 10'h029, 32'h80);
		repeat (64 * SLB_T + 100) @(posedge clk);
		rchk("lookup drained", fph_pkg::OFF_LVL + 10'h01f, 32'h0);
		rchk("neighbour idle", fph_pkg::OFF_LVL + 10'h01e, 32'h0);
		$display("test lookup done");
	endtask

	// Service 1 coupled, colour-aware, zero thresholds: bucket one sums stay zero and fill at once
	task automatic t_service();
		wr(fph_pkg::OFF_DCFG + 10'h001, 32'h30);
		f = mk(2'h2, 14'h0064, 2'h0, 4'h9, 4'h0);
		frame(f, '0, 1'b1, '{3'h1, 1'b0, 1'b0}, 0);
		frame(f, '{1'b0, 1'b1, 2'h1}, 1'b1, '{3'h1, 1'b0, 1'b1}, 0);
		f.drop_precedence = 2'h1;
		frame(f, '{1'b1, 1'b0, 2'h0}, 1'b1, '{3'h1, 1'b1, 1'b0}, 0);
		rdreg(fph_pkg::OFF_EVENTS, rd);
		check("dual drop flag", 32'(rd[fph_pkg::EV_DLB_DROP]), 32'h1);
		f = mk(2'h2, 14'h0064, 2'h2, 4'hb, 4'h9);
		frame(f, '{1'b0, 1'b1, 2'h2}, 1'b1, '{3'h3, 1'b0, 1'b0}, 0);
		rchk("bundle level", fph_pkg::OFF_LVL + 10'h04b, 32'h64);
		f.policing_pipeline_point = fph_pkg::PP_BDL;
		frame(f, '{1'b0, 1'b0, 2'h2}, 1'b0, '0, 0);
		$display("test service done");
	endtask

	// Non-service frame: queue policer 3, port bundle 2, multicast bucket
	task automatic t_queue();
		wr(fph_pkg::OFF_CTL, 32'hf);
		wr(fph_pkg::OFF_PCTL + 10'h003, 32'h100);
		f = mk(2'h3, 14'h0032, 2'h0, 4'h0, 4'h0);
		f.bum_en = 1'b1;
		f.bum_idx = 2'h1;
		f.bum_class = 2'h2;
		frame(f, '0, 1'b1, '{3'h3, 1'b0, 1'b0}, 0);
		rchk("port bundle level", fph_pkg::OFF_LVL + 10'h04c, 32'h32);
		rchk("multicast level", fph_pkg::OFF_LVL + 10'h031, 32'h32);
		rchk("unicast level", fph_pkg::OFF_LVL + 10'h030, 32'h0);
		// Coarse granularity on bundle 2: one rate unit empties 50 bytes in one tick
		wr(fph_pkg::OFF_BCFG + 10'h04c, 32'h1);
		wr(fph_pkg::OFF_DCFG + 10'h00a, 32'h1);
		repeat (64) @(posedge clk);
		rchk("coarse drain", fph_pkg::OFF_LVL + 10'h04c, 32'h0);
		$display("test queue done");
	endtask

	// Reset for two cycles, then the scenarios in turn
	initial begin
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		err_total = 0;
		checks_done = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_regs();
		t_port();
		t_lookup();
		t_service();
		t_queue();
		results();
	end
endmodule
